/* src/fifo_ctl_cfg.svh */
/*
  offsets, reset values and timing counts of the dual-clock fifo control.
  assumes nothing; included by bare name.
*/
`ifndef FIFO_CTL_CFG_SVH
`define FIFO_CTL_CFG_SVH
`define OFS_DEFAULT_PAR 10'h07F
`define OFS_DEFAULT_SER 10'h3FF
`define OUT_RESET_VAL   9'h000
`define FT_LATENCY      2'h3
`define MODE_REG_ADDR   32'h0000_0000
`define STAT_REG_ADDR   32'h0000_0004
`define EOFS_REG_ADDR   32'h0000_0008
`define FOFS_REG_ADDR   32'h0000_000C
`endif

/* src/fifo_ctl_pkg.sv */
/*
  types of the dual-clock fifo control.
  assumes fifo_ctl_cfg.svh is on the include path.
*/
package fifo_ctl_pkg;
  typedef enum logic [1:0] {
    MODE_PLAIN = 2'b01,
    MODE_FALL  = 2'b10
  } read_mode_t;
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] prev;
  } clk_sync_t;
endpackage

/* src/clk_edge_if.sv */
/*
  carries the rising edge strobes of the sampled write and read clocks.
  assumes one hclk domain.
*/
`timescale 1ns/100ps
interface clk_edge_if;
  logic wr_rise; // write clock rose
  logic rd_rise; // read clock rose
  modport src (output wr_rise, output rd_rise);
  modport dst (input wr_rise, input rd_rise);
endinterface // clk_edge_if

/* src/clk_edge_det.sv */
/*
  two-flop samplers of the write and read clock pins, rising edge detect.
  assumes hclk much faster than either pin clock.
*/
`timescale 1ns/100ps
module clk_edge_det
  import fifo_ctl_pkg::*;
(
  input  wire logic hclk,    // system clock
  input  wire logic hresetn, // async reset, active low
  input  wire logic wr_clk,  // write clock pin
  input  wire logic rd_clk,  // read clock pin
  clk_edge_if.src   edges    // edge strobes
);
  clk_sync_t st_q;
  clk_sync_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = {wr_clk, rd_clk};
    st_d.s2 = st_q.s1;
    st_d.prev = st_q.s2;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign edges.wr_rise = st_q.s2[1] & ~st_q.prev[1];
  assign edges.rd_rise = st_q.s2[0] & ~st_q.prev[0];
endmodule // clk_edge_det

/* src/fifo_ctl.sv */
/*
  dual-clock fifo control: storage, pointers, status flags, retransmit,
  reset-time mode and offset selection, ahb-lite register window.
  assumes pin inputs are asynchronous to hclk and the write and read clocks
  are sampled by hclk, which runs well above both.
*/
// The register addresses and the AHB-Lite slave port were decided locally.
// What this block does
// - full reset rewinds pointers, sets flag levels
// - strap low selects plain mode, empty/full
// - strap high selects fall-through, valid/space
// - load low: offsets 127, no offset loading
// - load high: offsets 1023, serial only
// - offsets always readable in parallel
// - full reset clears output, sampled on hclk
// - partial reset rewinds pointers, keeps mode
// - partial reset keeps offsets, clears output
// - replay low on read edge, both enables high, starts setup
// - plain replay: empty low, then reads
// - fall-through replay: first word shown
// - plain mode: words only on request
// - fall-through first word after three edges
// - strap pin becomes serial offset input
// - write stores one word unless full or load low
// - full flag returns two write edges later
// - space flag returns two write edges later
// - idle write clock freezes its flags
// - idle read clock freezes its flags
// - works with independent or shared clocks
`timescale 1ns/100ps
`include "fifo_ctl_cfg.svh"
module fifo_ctl
  import fifo_ctl_pkg::*;
#(
  parameter int AW = 4, // address bits of the storage
  parameter int DW = 9  // data width
) (
  input  wire logic          hclk,                       // system clock
  input  wire logic          hresetn,                    // async reset, active low
  input  wire logic          hsel,                       // slave select
  input  wire logic [31:0]   haddr,                      // byte address
  input  wire logic [1:0]    htrans,                     // transfer type
  input  wire logic          hwrite,                     // write when high
  input  wire logic [2:0]    hsize,                      // transfer size
  input  wire logic [31:0]   hwdata,                     // write data
  input  wire logic          hready,                     // bus ready in
  output logic               hreadyout,                  // slave ready
  output logic               hresp,                      // always okay
  output logic [31:0]        hrdata,                     // read data
  input  wire logic          full_reset_n,               // full reset pin
  input  wire logic          part_reset_n,               // partial reset pin
  input  wire logic          fall_through_sel_serial_in, // mode strap, serial in
  input  wire logic          offset_load_n,              // offset method strap
  input  wire logic          serial_en_n,                // serial load enable
  input  wire logic          wr_clk,                     // write clock pin
  input  wire logic          rd_clk,                     // read clock pin
  input  wire logic          wr_enable_n,                // write enable
  input  wire logic          rd_enable_n,                // read enable
  input  wire logic          replay_n,                   // retransmit request
  input  wire logic [DW-1:0] data_in,                    // write data
  output logic [DW-1:0]      data_out,                   // output register
  output logic               empty_n,                    // plain empty flag
  output logic               full_n,                     // plain full flag
  output logic               out_valid_n,                // fall-through ready
  output logic               space_avail_n,              // fall-through space
  output logic               almost_empty_n,             // almost empty
  output logic               almost_full_n,              // almost full
  output logic               half_full_n                 // half full
);
  localparam int PW = AW + 1;
  localparam logic [31:0] MODE_ADDR = `MODE_REG_ADDR;
  localparam logic [31:0] STAT_ADDR = `STAT_REG_ADDR;
  localparam logic [31:0] EOFS_ADDR = `EOFS_REG_ADDR;

  typedef struct packed {
    logic [2:0]    rst_s1;     // full, partial reset, replay samplers
    logic [2:0]    rst_s2;
    logic [4:0]    pin_s1;     // wr_en, rd_en, ser_in, load, ser_en
    logic [4:0]    pin_s2;
    logic [DW-1:0] din_s1;
    logic [DW-1:0] din_s2;
    logic          strap_done;
    read_mode_t    mode;
    logic          serial_sel;
    logic [9:0]    e_ofs;
    logic [9:0]    f_ofs;
    logic [4:0]    ser_cnt;
    logic [19:0]   ser_shift;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [PW-1:0] wg_s1;      // write gray seen in read domain
    logic [PW-1:0] wg_s2;
    logic [PW-1:0] rg_s1;      // read gray seen in write domain
    logic [PW-1:0] rg_s2;
    logic [1:0]    ft_cnt;
    logic          out_full;   // fall-through output register holds a word
    logic [DW-1:0] dout;
    logic          empty_f;
    logic          full_f;
    logic          ae_f;
    logic          af_f;
    logic          hf_f;
    logic          ahb_pend;
    logic          ahb_wr;
    logic [3:0]    ahb_addr;
    logic [31:0]   rdata;
  } state_t;

  state_t st_q;
  state_t st_d;
  logic [DW-1:0] mem_q [2**AW];
  logic          mem_we;
  clk_edge_if    edges ();

  clk_edge_det u_edges (
    .hclk    (hclk),
    .hresetn (hresetn),
    .wr_clk  (wr_clk),
    .rd_clk  (rd_clk),
    .edges   (edges)
  );

  function automatic logic [PW-1:0] to_gray(input logic [PW-1:0] b);
    to_gray = b ^ (b >> 1);
  endfunction

  function automatic logic [PW-1:0] from_gray(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = '0;
    for (int i = PW - 1; i >= 0; i--) begin
      b[i] = (i == PW - 1) ? g[i] : (b[i + 1] ^ g[i]);
    end
    from_gray = b;
  endfunction

  logic          full_rst;
  logic          any_rst;
  logic          wr_en;
  logic          rd_en;
  logic          ld_low;
  logic [PW-1:0] w_rptr;
  logic [PW-1:0] r_wptr;
  logic [PW-1:0] wlevel;
  logic [PW-1:0] rlevel;
  logic          can_rd;

  always_comb begin
    st_d = st_q;
    st_d.rst_s1 = {full_reset_n, part_reset_n, replay_n};
    st_d.rst_s2 = st_q.rst_s1;
    st_d.pin_s1 = {wr_enable_n, rd_enable_n, fall_through_sel_serial_in,
                   offset_load_n, serial_en_n};
    st_d.pin_s2 = st_q.pin_s1;
    st_d.din_s1 = data_in;
    st_d.din_s2 = st_q.din_s1;
    full_rst = !st_q.rst_s2[2];
    any_rst  = full_rst || !st_q.rst_s2[1];
    wr_en    = !st_q.pin_s2[4];
    rd_en    = !st_q.pin_s2[3];
    ld_low   = !st_q.pin_s2[1];
    mem_we   = 1'b0;
    w_rptr   = from_gray(st_q.rg_s2);
    r_wptr   = from_gray(st_q.wg_s2);
    wlevel   = st_q.wptr - w_rptr;
    rlevel   = r_wptr - st_q.rptr;
    can_rd   = rlevel != '0;

    if (full_rst) begin
      st_d.mode       = st_q.pin_s2[2] ? MODE_FALL : MODE_PLAIN;
      st_d.serial_sel = st_q.pin_s2[1];
      st_d.e_ofs      = st_q.pin_s2[1] ? `OFS_DEFAULT_SER : `OFS_DEFAULT_PAR;
      st_d.f_ofs      = st_d.e_ofs;
      st_d.ser_cnt    = '0;
      st_d.strap_done = 1'b1;
    end
    if (any_rst) begin
      st_d.wptr     = '0;
      st_d.rptr     = '0;
      st_d.wg_s1    = '0;
      st_d.wg_s2    = '0;
      st_d.rg_s1    = '0;
      st_d.rg_s2    = '0;
      st_d.ft_cnt   = '0;
      st_d.out_full = 1'b0;
      st_d.dout     = `OUT_RESET_VAL;
      st_d.empty_f  = 1'b1;
      st_d.full_f   = 1'b0;
      st_d.ae_f     = 1'b1;
      st_d.af_f     = 1'b0;
      st_d.hf_f     = 1'b0;
    end else begin
      // write domain, only on write clock edges
      if (edges.wr_rise) begin
        st_d.rg_s1 = to_gray(st_q.rptr);
        st_d.rg_s2 = st_q.rg_s1;
        if (ld_low && st_q.serial_sel && !st_q.pin_s2[0]) begin
          st_d.ser_shift = {st_q.ser_shift[18:0], st_q.pin_s2[2]};
          st_d.ser_cnt   = (st_q.ser_cnt == 5'd19) ? 5'd0 : st_q.ser_cnt + 5'd1;
          if (st_q.ser_cnt == 5'd19) begin
            st_d.e_ofs = st_d.ser_shift[19:10];
            st_d.f_ofs = st_d.ser_shift[9:0];
          end
        end else if (wr_en && !ld_low && !st_q.full_f) begin
          mem_we    = 1'b1;
          st_d.wptr = st_q.wptr + 1'b1;
        end
        // flags follow the two-stage synchronised read pointer, as loaded on this edge
        wlevel      = st_q.wptr - from_gray(st_d.rg_s2);
        st_d.full_f = wlevel[AW] || (mem_we && wlevel == PW'(2**AW - 1));
        st_d.af_f   = wlevel >= PW'(2**AW) - PW'(st_q.f_ofs[AW:0]);
        if (wlevel >= PW'(2**(AW - 1))) begin
          st_d.hf_f = 1'b1;
        end
      end
      // read domain, only on read clock edges
      if (edges.rd_rise) begin
        st_d.wg_s1 = to_gray(st_q.wptr);
        st_d.wg_s2 = st_q.wg_s1;
        if (!st_q.rst_s2[0] && !rd_en && wr_en == 1'b0) begin
          st_d.rptr     = '0;
          st_d.empty_f  = 1'b1;
          st_d.out_full = 1'b0;
          st_d.ft_cnt   = '0;
        end else if (st_q.mode == MODE_PLAIN) begin
          st_d.empty_f = !can_rd;
          if (rd_en && !ld_low && can_rd) begin
            st_d.dout = mem_q[st_q.rptr[AW-1:0]];
            st_d.rptr = st_q.rptr + 1'b1;
          end
        end else begin
          // two synchroniser edges plus this load make the three-edge latency
          if (can_rd && (!st_q.out_full || (rd_en && !ld_low))) begin
            st_d.dout     = mem_q[st_q.rptr[AW-1:0]];
            st_d.rptr     = st_q.rptr + 1'b1;
            st_d.out_full = 1'b1;
            st_d.ft_cnt   = '0;
          end else if (rd_en && !ld_low && st_q.out_full) begin
            st_d.out_full = 1'b0;
          end
          st_d.empty_f = !st_d.out_full;
        end
        st_d.ae_f = rlevel <= PW'(st_q.e_ofs[AW:0]);
        if (rlevel < PW'(2**(AW - 1))) begin
          st_d.hf_f = 1'b0;
        end
      end
    end

    // ahb-lite slave, single-cycle answers
    if (st_q.ahb_pend && st_q.ahb_wr && st_q.ahb_addr == MODE_ADDR[3:0]) begin
      st_d.strap_done = hwdata[0] | st_q.strap_done;
    end
    st_d.ahb_pend = hsel && hready && htrans[1];
    st_d.ahb_wr   = hwrite;
    st_d.ahb_addr = haddr[3:0];
    unique case (haddr[3:0])
      MODE_ADDR[3:0]: st_d.rdata = {29'h0, st_q.serial_sel, st_q.mode};
      STAT_ADDR[3:0]: st_d.rdata = {27'h0, st_q.empty_f, st_q.full_f,
                                    st_q.ae_f, st_q.af_f, st_q.hf_f};
      EOFS_ADDR[3:0]: st_d.rdata = {22'h0, st_q.e_ofs};
      default:               st_d.rdata = {22'h0, st_q.f_ofs};
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge hclk) begin
    if (mem_we) begin
      mem_q[st_q.wptr[AW-1:0]] <= st_q.din_s2;
    end
  end

  logic plain;
  assign plain          = st_q.mode != MODE_FALL;
  assign data_out       = st_q.dout;
  assign empty_n        = plain ? !st_q.empty_f : 1'b0;
  assign full_n         = plain ? !st_q.full_f : 1'b1;
  assign out_valid_n    = plain ? 1'b1 : st_q.empty_f;
  assign space_avail_n  = plain ? 1'b0 : st_q.full_f;
  assign almost_empty_n = !st_q.ae_f;
  assign almost_full_n  = !st_q.af_f;
  assign half_full_n    = !st_q.hf_f;
  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign hrdata         = st_q.rdata;
endmodule // fifo_ctl

/* tb/fifo_ctl_sva.sv */
/*
  concurrent checks on the fifo control top ports, bound into fifo_ctl.
  assumes pin clocks slow beside hclk: six still hclk cover one sample.
*/
`timescale 1ns/100ps
module fifo_ctl_sva
  import fifo_ctl_pkg::*;
#(
  parameter int AW = 4, // storage address bits
  parameter int DW = 9  // data width
) (
  input wire logic          hclk,                       // clock
  input wire logic          hresetn,                    // reset
  input wire logic          hsel,                       // bus select
  input wire logic          full_reset_n,               // full reset
  input wire logic          part_reset_n,               // partial reset
  input wire logic          fall_through_sel_serial_in, // mode strap
  input wire logic          wr_clk,                     // write clock
  input wire logic          rd_clk,                     // read clock
  input wire logic [DW-1:0] data_out,                   // output word
  input wire logic          empty_n,                    // empty
  input wire logic          full_n,                     // full
  input wire logic          out_valid_n,                // output ready
  input wire logic          space_avail_n,              // input ready
  input wire logic          almost_empty_n,             // almost empty
  input wire logic          almost_full_n,              // almost full
  input wire logic          half_full_n                 // half full
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence full_rst(s);
    (!full_reset_n && fall_through_sel_serial_in == s)[*4]
      ##1 (full_reset_n && fall_through_sel_serial_in == s)[*3];
  endsequence
  sequence part_rst;
    (full_reset_n && !part_reset_n)[*4];
  endsequence
  sequence wr_quiet;
    ($stable(wr_clk) && full_reset_n && part_reset_n && !hsel)[*6];
  endsequence
  sequence rd_quiet;
    ($stable(rd_clk) && full_reset_n && part_reset_n && !hsel)[*6];
  endsequence
  full_flags_a: assert property ((!full_reset_n)[*4] |-> !almost_empty_n && almost_full_n
    && half_full_n && data_out == '0) else $error("full reset flags wrong");
  plain_sel_a: assert property (full_rst(1'b0) |-> !empty_n && full_n)
    else $error("plain mode flags wrong");
  fall_sel_a: assert property (full_rst(1'b1) |-> out_valid_n && !space_avail_n)
    else $error("fall-through flags wrong");
  part_flags_a: assert property (part_rst |-> !almost_empty_n && almost_full_n
    && half_full_n && data_out == '0) else $error("partial reset flags wrong");
  part_mode_a: assert property (part_rst |-> (!empty_n && full_n)
    || (out_valid_n && !space_avail_n)) else $error("partial reset mode flags wrong");
  wr_idle_a: assert property (wr_quiet |-> $stable(full_n) && $stable(space_avail_n)
    && $stable(almost_full_n) && !$fell(half_full_n)) else $error("write flags moved");
  rd_idle_a: assert property (rd_quiet |-> $stable(empty_n) && $stable(out_valid_n)
    && $stable(almost_empty_n) && !$rose(half_full_n)) else $error("read flags moved");
  out_hold_a: assert property (rd_quiet |-> $stable(data_out))
    else $error("output word moved");
endmodule // fifo_ctl_sva
bind fifo_ctl fifo_ctl_sva #(.AW(AW), .DW(DW)) i_sva (.*);

/* tb/fifo_link_model.sv */
/*
  writer and reader on the pin clocks; a clock pulses only per call.
  assumes hclk is the bench clock; calls run one at a time.
*/
`timescale 1ns/100ps
module fifo_link_model (
  input  wire logic hclk,        // bench clock
  output logic      wr_clk,      // write clock pin
  output logic      rd_clk,      // read clock pin
  output logic      wr_enable_n, // write enable
  output logic      rd_enable_n, // read enable
  output logic      replay_n,    // retransmit request
  output logic [8:0] data_in     // write word
);
  initial begin
    {wr_clk, rd_clk} = 2'b00;
    {wr_enable_n, rd_enable_n, replay_n} = 3'b111;
    data_in = 9'h155;
  end
  // one 180 ns period on the chosen clocks; enables held across the rise
  task automatic cyc(input logic w, input logic r, input logic wen_n, input logic ren_n,
                     input logic rt_n, input logic [8:0] d);
    @(posedge hclk);
    wr_enable_n <= wen_n;
    rd_enable_n <= ren_n | ~rt_n;
    replay_n <= rt_n;
    data_in <= d;
    repeat (4) @(posedge hclk);
    wr_clk <= w;
    rd_clk <= r;
    repeat (4) @(posedge hclk);
    {wr_clk, rd_clk} <= 2'b00;
    {wr_enable_n, rd_enable_n, replay_n} <= 3'b111;
    data_in <= ~d; // released bus shows no stale word
    @(negedge hclk);
  endtask
endmodule // fifo_link_model

/* tb/tb_top.sv */
/*
  self-checking bench of the fifo control: reset straps, fill, replay, serial load.
  assumes fifo_ctl_cfg.svh on the include path; depth 16.
*/
`timescale 1ns/100ps
`include "fifo_ctl_cfg.svh"
module tb_top
  import fifo_ctl_pkg::*;
;
  typedef struct packed {logic ft; logic ld; read_mode_t mode; logic [9:0] ofs;} row_t;
  row_t rows [4] = '{'{1'b0, 1'b0, MODE_PLAIN, `OFS_DEFAULT_PAR},
                     '{1'b0, 1'b1, MODE_PLAIN, `OFS_DEFAULT_SER},
                     '{1'b1, 1'b0, MODE_FALL, `OFS_DEFAULT_PAR},
                     '{1'b1, 1'b1, MODE_FALL, `OFS_DEFAULT_SER}};
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        full_reset_n, part_reset_n, fall_through_sel_serial_in, offset_load_n;
  logic        serial_en_n, wr_clk, rd_clk, wr_enable_n, rd_enable_n, replay_n;
  logic [8:0]  data_in, data_out;
  logic        empty_n, full_n, out_valid_n, space_avail_n;
  logic        almost_empty_n, almost_full_n, half_full_n;
  logic [19:0] sv = {10'h012, 10'h345};
  int          n_mismatch, n_compared;
  assign hready = hreadyout;
  fifo_ctl #(.AW(4)) i_dut (.*);
  fifo_link_model i_lnk (.*);
  initial hclk = 1'b0;
  always #10 hclk = ~hclk;
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    {hsel, htrans, haddr, hwrite} <= {1'b1, 2'b10, a, w};
    do @(posedge hclk); while (hready !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  // full or partial reset pulse, straps held past release
  task automatic rst(input logic full, input logic ft, input logic ld);
    @(posedge hclk);
    {fall_through_sel_serial_in, offset_load_n} <= {ft, ld};
    if (full) full_reset_n <= 1'b0;
    else part_reset_n <= 1'b0;
    repeat (4) @(posedge hclk);
    {full_reset_n, part_reset_n} <= 2'b11;
    repeat (4) @(posedge hclk);
    offset_load_n <= 1'b1;
    repeat (3) @(posedge hclk);
  endtask
  task automatic wr(input logic [8:0] d);
    i_lnk.cyc(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, d);
  endtask
  task automatic rd(input logic ren_n);
    i_lnk.cyc(1'b0, 1'b1, 1'b1, ren_n, 1'b1, 9'h000);
  endtask
  initial begin
    {hresetn, full_reset_n, part_reset_n, hsel, hwrite} = 5'b00100;
    {fall_through_sel_serial_in, offset_load_n, serial_en_n} = 3'b001;
    {htrans, hsize, haddr, hwdata} = {2'b00, 3'b010, 64'h0000_0000_0000_0000};
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i]) begin
      rst(1'b1, rows[i].ft, rows[i].ld);
      ahb(1'b0, `MODE_REG_ADDR, 32'h0000_0000);
      chk("mode", q, 32'({rows[i].ld, rows[i].mode}));
      ahb(1'b0, `EOFS_REG_ADDR, 32'h0000_0000);
      chk("empty offset", q, 32'(rows[i].ofs));
      ahb(1'b0, `FOFS_REG_ADDR, 32'h0000_0000);
      chk("full offset", q, 32'(rows[i].ofs));
      chk("mode flags", 32'(rows[i].ft ? {out_valid_n, space_avail_n} : {empty_n, full_n}),
          rows[i].ft ? 32'h0000_0002 : 32'h0000_0001);
      chk("common", 32'({almost_empty_n, almost_full_n, half_full_n, data_out}),
          32'h0000_0600);
    end
    $display("test reset straps done");
    rst(1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 16; i++) wr(9'(i * 3 + 1));
    rd(1'b1);
    rd(1'b1);
    chk("unrequested word", 32'(data_out), 32'h0000_0000);
    chk("full", 32'(full_n), 32'h0000_0000);
    wr(9'h1FF);
    rd(1'b0);
    chk("first word", 32'(data_out), 32'h0000_0001);
    i_lnk.cyc(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 9'h000);
    i_lnk.cyc(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 9'h000);
    chk("full released", 32'(full_n), 32'h0000_0001);
    for (int i = 1; i < 16; i++) begin
      rd(1'b0);
      chk("drain word", 32'(data_out), 32'(i * 3 + 1));
    end
    rd(1'b0);
    chk("empty read", 32'({empty_n, data_out}), 32'h0000_002E);
    $display("test plain fill done");
    rst(1'b0, 1'b0, 1'b0);
    chk("plain kept", 32'({empty_n, full_n, data_out}), 32'h0000_0200);
    wr(9'h011);
    wr(9'h022);
    wr(9'h033);
    rd(1'b1);
    rd(1'b1);
    rd(1'b0);
    rd(1'b0);
    i_lnk.cyc(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 9'h000);
    chk("replay empty", 32'(empty_n), 32'h0000_0000);
    repeat (3) rd(1'b1);
    chk("replay done", 32'({empty_n, data_out}), 32'h0000_0222);
    rd(1'b0);
    chk("replay word", 32'(data_out), 32'h0000_0011);
    $display("test plain replay done");
    rst(1'b1, 1'b1, 1'b1);
    ahb(1'b1, `EOFS_REG_ADDR, 32'h0000_0005);
    ahb(1'b0, `EOFS_REG_ADDR, 32'h0000_0000);
    chk("parallel refused", q, 32'h0000_03FF);
    ahb(1'b0, 32'h0000_0010, 32'h0000_0000);
    chk("unmapped", q, 32'({1'b1, MODE_FALL}));
    wr(9'h0A5);
    wr(9'h15A);
    rd(1'b1);
    rd(1'b1);
    chk("two edges", 32'(data_out), 32'h0000_0000);
    rd(1'b1);
    chk("fell through", 32'({out_valid_n, data_out}), 32'h0000_00A5);
    rd(1'b0);
    chk("second word", 32'(data_out), 32'h0000_015A);
    i_lnk.cyc(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 9'h000);
    chk("replay busy", 32'(out_valid_n), 32'h0000_0001);
    repeat (3) rd(1'b1);
    chk("replay shown", 32'({out_valid_n, data_out}), 32'h0000_00A5);
    @(posedge hclk);
    {offset_load_n, serial_en_n} <= 2'b00;
    for (int i = 19; i >= 0; i--) begin
      @(posedge hclk);
      fall_through_sel_serial_in <= sv[i];
      i_lnk.cyc(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 9'h000);
    end
    @(posedge hclk);
    {offset_load_n, serial_en_n} <= 2'b11;
    rst(1'b0, 1'b1, 1'b1);
    chk("fall kept", 32'({out_valid_n, space_avail_n, data_out}), 32'h0000_0400);
    ahb(1'b0, `MODE_REG_ADDR, 32'h0000_0000);
    chk("mode kept", q, 32'({1'b1, MODE_FALL}));
    ahb(1'b0, `EOFS_REG_ADDR, 32'h0000_0000);
    chk("serial empty", q, 32'h0000_0012);
    ahb(1'b0, `FOFS_REG_ADDR, 32'h0000_0000);
    chk("serial full", q, 32'h0000_0345);
    $display("test fall-through done");
    close_out();
  end
  // about 18 us of tests; a hang stops well past that
  initial begin
    #400_000;
    n_mismatch++;
    close_out();
  end
endmodule // tb_top
